// file: core/dsb_defines.vh
`ifndef DSB_DEFINES_VH
`define DSB_DEFINES_VH

// Byte offsets of the registers on the AXI4-Lite slave.
`define DSB_A_CTRL        8'h00
`define DSB_A_PRE_CUR     8'h04
`define DSB_A_PRE_DUR     8'h08
`define DSB_A_STOP_FREQ   8'h0c
`define DSB_A_STOP_WAIT   8'h10
`define DSB_A_STOP_CUR    8'h14
`define DSB_A_STOP_DUR    8'h18
`define DSB_A_DEAD        8'h1c
`define DSB_A_MAX_FREQ    8'h20
`define DSB_A_RAMP_STEP   8'h24
`define DSB_A_TARGET      8'h28
`define DSB_A_RATED_PWR   8'h2c
`define DSB_A_LEARN_SEL   8'h30
`define DSB_A_STATUS      8'h34
`define DSB_A_MP_BASE     8'h40
`define DSB_A_MP_LAST     8'h60
`define DSB_MP_COUNT      4'd9

// Control register fields.
`define DSB_C_START_SEL   0
`define DSB_C_STOP_SEL    1
`define DSB_C_GUARD       2
`define DSB_C_TERM_SRC    3
`define DSB_C_SOFT_RUN    4
`define DSB_C_SOFT_REV    5
`define DSB_CTRL_RST      6'h08

// Upper bounds of settings (0.1 % and 0.1 s units).
`define DSB_CUR_MAX       16'h05dc
`define DSB_DUR_MAX       16'h01f4
`define DSB_DEAD_MAX      16'h8ca0

// Reset values of the other settings.
`define DSB_MAX_FREQ_RST  16'h1388
`define DSB_RAMP_RST      16'h000a
`define DSB_PWR_RST       16'h0000

// Motor parameter defaults loaded when rated power is rewritten.
`define DSB_MP_DEF_0      16'h1388
`define DSB_MP_DEF_1      16'h0000
`define DSB_MP_DEF_2      16'h0000
`define DSB_MP_DEF_3      16'h0000
`define DSB_MP_DEF_4      16'h0001
`define DSB_MP_DEF_5      16'h0001
`define DSB_MP_DEF_6      16'h0001
`define DSB_MP_DEF_7      16'h0001
`define DSB_MP_DEF_8      16'h0001

// Timing: a 0.1 s tick from the 100 ns clock.
`define DSB_TICK_NS       100000000
`define DSB_CLK_PERIOD_NS 100
`define DSB_TICK_CYCLES   24'd1000000
`define DSB_POR_WAIT      2'd3

`endif

// file: core/dsb_param_mem.v
`timescale 1ns/1ps
`include "dsb_defines.vh"

// Motor parameter store: one write port, registered read data.
module dsb_param_mem (
  input wire clk,
  input wire ce,
  input wire we,
  input wire [3:0] waddr,
  input wire [15:0] wdata,
  input wire [3:0] raddr,
  output reg [15:0] rdata
);

  reg [15:0] mem [0:15];

  // Writes and reads happen only while the clock enable is high.
  always @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule // dsb_param_mem

// file: core/dsb_sequencer.v
`timescale 1ns/1ps
`include "dsb_defines.vh"

module dsb_sequencer #(
  parameter [23:0] TICK_CYCLES = `DSB_TICK_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire run_fwd_pin,
  input wire run_rev_pin,
  input wire learn_done,
  input wire [79:0] learn_params,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [15:0] out_freq_r,
  output reg out_dir_r,
  output reg drive_en_r,
  output reg brake_en_r,
  output reg [10:0] brake_level_r,
  output reg [1:0] learn_sel_r
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_PRE = 3'd1;
  localparam [2:0] S_RUN = 3'd2;
  localparam [2:0] S_REV = 3'd3;
  localparam [2:0] S_DEAD = 3'd4;
  localparam [2:0] S_SRAMP = 3'd5;
  localparam [2:0] S_SWAIT = 3'd6;
  localparam [2:0] S_SBRK = 3'd7;

  // Limits a setting to its upper bound.
  function [15:0] clamp16;
    input [15:0] v;
    input [15:0] m;
    begin
      clamp16 = (v > m) ? m : v;
    end
  endfunction

  // Applies byte strobes of a write to an old register value.
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (s[i]) begin
          wmerge[i*8 +: 8] = d[i*8 +: 8];
        end
      end
    end
  endfunction

  // Moves a frequency one step toward a target without overshoot.
  function [15:0] ramp;
    input [15:0] cur;
    input [15:0] tgt;
    input [15:0] step;
    begin
      if (cur < tgt) begin
        ramp = (tgt - cur > step) ? cur + step : tgt;
      end else begin
        ramp = (cur - tgt > step) ? cur - step : tgt;
      end
    end
  endfunction

  // Default motor parameter for a given index.
  function [15:0] mp_default;
    input [3:0] idx;
    begin
      case (idx)
        4'd0: mp_default = `DSB_MP_DEF_0;
        4'd1: mp_default = `DSB_MP_DEF_1;
        4'd2: mp_default = `DSB_MP_DEF_2;
        4'd3: mp_default = `DSB_MP_DEF_3;
        4'd4: mp_default = `DSB_MP_DEF_4;
        4'd5: mp_default = `DSB_MP_DEF_5;
        4'd6: mp_default = `DSB_MP_DEF_6;
        4'd7: mp_default = `DSB_MP_DEF_7;
        default: mp_default = `DSB_MP_DEF_8;
      endcase
    end
  endfunction

  reg [5:0] ctrl_r;
  reg [10:0] pre_cur_r;
  reg [15:0] pre_dur_r;
  reg [15:0] stop_freq_r;
  reg [15:0] stop_wait_r;
  reg [10:0] stop_cur_r;
  reg [15:0] stop_dur_r;
  reg [15:0] dead_r;
  reg [15:0] max_freq_r;
  reg [15:0] ramp_step_r;
  reg [15:0] target_r;
  reg [15:0] rated_pwr_r;
  reg pwr_wr_r;
  reg aw_full_r;
  reg w_full_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg rd_pend_r;
  reg [7:0] ar_addr_r;
  reg fwd_m_r;
  reg fwd_s_r;
  reg rev_m_r;
  reg rev_s_r;
  reg [1:0] por_cnt_r;
  reg por_done_r;
  reg lock_r;
  reg [2:0] state_r;
  reg [23:0] tick_cnt_r;
  reg [15:0] tmr_r;
  reg eng_busy_r;
  reg eng_mode_r;
  reg [3:0] eng_idx_r;
  reg init_pend_r;
  reg learn_pend_r;
  reg [79:0] learn_cap_r;
  wire [15:0] mp_rdata;

  wire term_src = ctrl_r[`DSB_C_TERM_SRC];
  wire term_any = fwd_s_r | rev_s_r;
  wire run_req = por_done_r & (term_src ? (term_any & ~lock_r) :
                 ctrl_r[`DSB_C_SOFT_RUN]);
  wire dir_req = term_src ? (rev_s_r & ~fwd_s_r) : ctrl_r[`DSB_C_SOFT_REV];
  wire tick = (tick_cnt_r == TICK_CYCLES - 24'd1);
  wire [15:0] brk_freq = clamp16(stop_freq_r, max_freq_r);
  wire [15:0] run_tgt = clamp16(target_r, max_freq_r);
  wire [31:0] wr_val = wmerge(32'h0, w_data_r, w_strb_r);
  wire [31:0] ctrl_mrg = wmerge({26'h0, ctrl_r}, w_data_r, w_strb_r);
  wire [15:0] cur_lim = clamp16(wr_val[15:0], `DSB_CUR_MAX);
  wire wr_mp = (aw_addr_r >= `DSB_A_MP_BASE) && (aw_addr_r <= `DSB_A_MP_LAST);
  wire wr_go = aw_full_r & w_full_r & ~s_axi_bvalid & ~(wr_mp & eng_busy_r);
  wire [7:0] wr_off = aw_addr_r - `DSB_A_MP_BASE;
  wire [7:0] rd_off = s_axi_araddr - `DSB_A_MP_BASE;
  wire [3:0] lidx = eng_idx_r - 4'd4;
  wire [15:0] eng_data = eng_mode_r ? learn_cap_r[{lidx[2:0], 4'h0} +: 16] :
                         mp_default(eng_idx_r);
  wire mem_we = eng_busy_r | (wr_go & wr_mp);
  wire [3:0] mem_waddr = eng_busy_r ? eng_idx_r : wr_off[5:2];
  wire [15:0] mem_wdata = eng_busy_r ? eng_data : w_data_r[15:0];

  dsb_param_mem u_mem (
    .clk(clk),
    .ce(ce),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(rd_off[5:2]),
    .rdata(mp_rdata)
  );

  // Run terminals pass two flip-flops; power-on sampling follows the wait.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fwd_m_r <= 1'b0;
      fwd_s_r <= 1'b0;
      rev_m_r <= 1'b0;
      rev_s_r <= 1'b0;
      por_cnt_r <= 2'd0;
      por_done_r <= 1'b0;
      lock_r <= 1'b0;
    end else if (ce) begin
      fwd_m_r <= run_fwd_pin;
      fwd_s_r <= fwd_m_r;
      rev_m_r <= run_rev_pin;
      rev_s_r <= rev_m_r;
      if (!por_done_r) begin
        if (por_cnt_r == `DSB_POR_WAIT) begin
          por_done_r <= 1'b1;
          // Lock only under terminal control with the guard at zero.
          lock_r <= term_src & ~ctrl_r[`DSB_C_GUARD] & term_any;
        end else begin
          por_cnt_r <= por_cnt_r + 2'd1;
        end
      end else if (!term_any) begin
        lock_r <= 1'b0;
      end
    end
  end

  // AXI4-Lite write channel and register stores.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      ctrl_r <= `DSB_CTRL_RST;
      pre_cur_r <= 11'h000;
      pre_dur_r <= 16'h0000;
      stop_freq_r <= 16'h0000;
      stop_wait_r <= 16'h0000;
      stop_cur_r <= 11'h000;
      stop_dur_r <= 16'h0000;
      dead_r <= 16'h0000;
      max_freq_r <= `DSB_MAX_FREQ_RST;
      ramp_step_r <= `DSB_RAMP_RST;
      target_r <= 16'h0000;
      rated_pwr_r <= `DSB_PWR_RST;
      learn_sel_r <= 2'b00;
      pwr_wr_r <= 1'b0;
    end else if (ce) begin
      pwr_wr_r <= 1'b0;
      if (learn_done) begin
        learn_sel_r <= 2'b00;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_full_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_full_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (aw_addr_r)
          `DSB_A_CTRL: ctrl_r <= ctrl_mrg[5:0];
          `DSB_A_PRE_CUR: pre_cur_r <= cur_lim[10:0];
          `DSB_A_PRE_DUR: pre_dur_r <= clamp16(wr_val[15:0], `DSB_DUR_MAX);
          `DSB_A_STOP_FREQ: stop_freq_r <= wr_val[15:0];
          `DSB_A_STOP_WAIT: stop_wait_r <= clamp16(wr_val[15:0], `DSB_DUR_MAX);
          `DSB_A_STOP_CUR: stop_cur_r <= cur_lim[10:0];
          `DSB_A_STOP_DUR:
            stop_dur_r <= clamp16(wr_val[15:0], `DSB_DUR_MAX);
          `DSB_A_DEAD: dead_r <= clamp16(wr_val[15:0], `DSB_DEAD_MAX);
          `DSB_A_MAX_FREQ: max_freq_r <= wr_val[15:0];
          `DSB_A_RAMP_STEP: ramp_step_r <= wr_val[15:0];
          `DSB_A_TARGET: target_r <= wr_val[15:0];
          `DSB_A_RATED_PWR: begin
            rated_pwr_r <= wr_val[15:0];
            pwr_wr_r <= 1'b1;
          end
          `DSB_A_LEARN_SEL: learn_sel_r <= wr_val[1:0];
          default: begin
            if (!wr_mp || wr_off[1:0] != 2'b00) begin
              s_axi_bresp <= 2'b10;
            end
          end
        endcase
      end
    end
  end

  // AXI4-Lite read channel; every read answers two cycles after it is taken.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
      rd_pend_r <= 1'b0;
      ar_addr_r <= 8'h00;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_addr_r <= s_axi_araddr;
        rd_pend_r <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (ar_addr_r)
          `DSB_A_CTRL: s_axi_rdata <= {26'h0, ctrl_r};
          `DSB_A_PRE_CUR: s_axi_rdata <= {21'h0, pre_cur_r};
          `DSB_A_PRE_DUR: s_axi_rdata <= {16'h0, pre_dur_r};
          `DSB_A_STOP_FREQ: s_axi_rdata <= {16'h0, stop_freq_r};
          `DSB_A_STOP_WAIT: s_axi_rdata <= {16'h0, stop_wait_r};
          `DSB_A_STOP_CUR: s_axi_rdata <= {21'h0, stop_cur_r};
          `DSB_A_STOP_DUR: s_axi_rdata <= {16'h0, stop_dur_r};
          `DSB_A_DEAD: s_axi_rdata <= {16'h0, dead_r};
          `DSB_A_MAX_FREQ: s_axi_rdata <= {16'h0, max_freq_r};
          `DSB_A_RAMP_STEP: s_axi_rdata <= {16'h0, ramp_step_r};
          `DSB_A_TARGET: s_axi_rdata <= {16'h0, target_r};
          `DSB_A_RATED_PWR: s_axi_rdata <= {16'h0, rated_pwr_r};
          `DSB_A_LEARN_SEL: s_axi_rdata <= {30'h0, learn_sel_r};
          `DSB_A_STATUS: s_axi_rdata <= {6'h0, lock_r, eng_busy_r,
                                         brake_en_r, drive_en_r, out_dir_r,
                                         2'b00, state_r, out_freq_r};
          default: begin
            s_axi_rdata <= {16'h0, mp_rdata};
            if (ar_addr_r < `DSB_A_MP_BASE || ar_addr_r > `DSB_A_MP_LAST ||
                ar_addr_r[1:0] != 2'b00) begin
              s_axi_rdata <= 32'h0;
              s_axi_rresp <= 2'b10;
            end
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Parameter engine: reload defaults or store identified values.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      eng_busy_r <= 1'b0;
      eng_mode_r <= 1'b0;
      eng_idx_r <= 4'd0;
      init_pend_r <= 1'b0;
      learn_pend_r <= 1'b0;
      learn_cap_r <= 80'h0;
    end else if (ce) begin
      if (learn_done) begin
        learn_cap_r <= learn_params;
      end
      if (eng_busy_r) begin
        if (eng_idx_r == `DSB_MP_COUNT - 4'd1) begin
          eng_busy_r <= 1'b0;
        end else begin
          eng_idx_r <= eng_idx_r + 4'd1;
        end
      end else if (learn_pend_r) begin
        eng_busy_r <= 1'b1;
        eng_mode_r <= 1'b1;
        eng_idx_r <= 4'd4;
      end else if (init_pend_r) begin
        eng_busy_r <= 1'b1;
        eng_mode_r <= 1'b0;
        eng_idx_r <= 4'd0;
      end
      // A new request wins over the clear of its pending flag.
      if (!eng_busy_r && learn_pend_r) begin
        learn_pend_r <= learn_done;
      end else if (learn_done) begin
        learn_pend_r <= 1'b1;
      end
      if (!eng_busy_r && !learn_pend_r && init_pend_r) begin
        init_pend_r <= pwr_wr_r;
      end else if (pwr_wr_r) begin
        init_pend_r <= 1'b1;
      end
    end
  end

  // Start, run, reversal and stop sequencing on 0.1 s ticks.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      tick_cnt_r <= 24'd0;
      tmr_r <= 16'h0000;
      out_freq_r <= 16'h0000;
      out_dir_r <= 1'b0;
      drive_en_r <= 1'b0;
      brake_en_r <= 1'b0;
      brake_level_r <= 11'h000;
    end else if (ce) begin
      tick_cnt_r <= tick ? 24'd0 : tick_cnt_r + 24'd1;
      case (state_r)
        S_IDLE: begin
          drive_en_r <= 1'b0;
          brake_en_r <= 1'b0;
          out_freq_r <= 16'h0000;
          if (run_req) begin
            out_dir_r <= dir_req;
            drive_en_r <= 1'b1;
            tick_cnt_r <= 24'd0;
            if (ctrl_r[`DSB_C_START_SEL] && pre_dur_r != 16'h0000) begin
              state_r <= S_PRE;
              tmr_r <= pre_dur_r;
              brake_en_r <= 1'b1;
              brake_level_r <= pre_cur_r;
            end else begin
              state_r <= S_RUN;
            end
          end
        end
        S_PRE: begin
          if (!run_req) begin
            state_r <= S_IDLE;
            drive_en_r <= 1'b0;
            brake_en_r <= 1'b0;
          end else if (tick) begin
            if (tmr_r <= 16'h0001) begin
              state_r <= S_RUN;
              brake_en_r <= 1'b0;
            end else begin
              tmr_r <= tmr_r - 16'h0001;
            end
          end
        end
        S_RUN, S_REV: begin
          if (!run_req) begin
            tick_cnt_r <= 24'd0;
            if (ctrl_r[`DSB_C_STOP_SEL]) begin
              state_r <= S_IDLE;
              drive_en_r <= 1'b0;
              out_freq_r <= 16'h0000;
            end else begin
              state_r <= S_SRAMP;
            end
          end else if (dir_req != out_dir_r) begin
            state_r <= S_REV;
            if (out_freq_r == 16'h0000) begin
              state_r <= (dead_r == 16'h0000) ? S_RUN : S_DEAD;
              out_dir_r <= (dead_r == 16'h0000) ? dir_req : out_dir_r;
              tmr_r <= dead_r;
              tick_cnt_r <= 24'd0;
            end else if (tick) begin
              out_freq_r <= ramp(out_freq_r, 16'h0000, ramp_step_r);
            end
          end else begin
            state_r <= S_RUN;
            if (tick) begin
              out_freq_r <= ramp(out_freq_r, run_tgt, ramp_step_r);
            end
          end
        end
        S_DEAD: begin
          out_freq_r <= 16'h0000;
          if (!run_req) begin
            state_r <= S_IDLE;
            drive_en_r <= 1'b0;
          end else if (dir_req == out_dir_r) begin
            state_r <= S_RUN;
          end else if (tick) begin
            if (tmr_r <= 16'h0001) begin
              state_r <= S_RUN;
              out_dir_r <= dir_req;
            end else begin
              tmr_r <= tmr_r - 16'h0001;
            end
          end
        end
        S_SRAMP: begin
          if (run_req) begin
            state_r <= S_RUN;
          end else if (stop_dur_r != 16'h0000 && out_freq_r <= brk_freq) begin
            out_freq_r <= 16'h0000;
            tick_cnt_r <= 24'd0;
            if (stop_wait_r != 16'h0000) begin
              state_r <= S_SWAIT;
              tmr_r <= stop_wait_r;
              drive_en_r <= 1'b0;
            end else begin
              state_r <= S_SBRK;
              tmr_r <= stop_dur_r;
              brake_en_r <= 1'b1;
              brake_level_r <= stop_cur_r;
            end
          end else if (out_freq_r == 16'h0000) begin
            state_r <= S_IDLE;
            drive_en_r <= 1'b0;
          end else if (tick) begin
            out_freq_r <= ramp(out_freq_r, 16'h0000, ramp_step_r);
          end
        end
        S_SWAIT: begin
          if (tick) begin
            if (tmr_r <= 16'h0001) begin
              state_r <= S_SBRK;
              tmr_r <= stop_dur_r;
              drive_en_r <= 1'b1;
              brake_en_r <= 1'b1;
              brake_level_r <= stop_cur_r;
            end else begin
              tmr_r <= tmr_r - 16'h0001;
            end
          end
        end
        default: begin
          if (tick) begin
            if (tmr_r <= 16'h0001) begin
              state_r <= S_IDLE;
              drive_en_r <= 1'b0;
              brake_en_r <= 1'b0;
            end else begin
              tmr_r <= tmr_r - 16'h0001;
            end
          end
        end
      endcase
    end
  end

endmodule // dsb_sequencer

// file: tb/dsb_sequencer_asserts.sv
`timescale 1ns/1ps
module dsb_seq_chk (
  input wire clk,
  input wire rst,
  input wire learn_done,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire drive_en_r,
  input wire brake_en_r,
  input wire [10:0] brake_level_r,
  input wire [1:0] learn_sel_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Handshake steps shared by the bus properties.
  sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_rd_lat; s_rd_take |=> !s_axi_rvalid ##1 s_axi_rvalid; endproperty
  property p_ar_block; s_rd_take |=> !s_axi_arready; endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_wr_resp; s_wr_take |-> ##[1:12] s_axi_bvalid; endproperty
  property p_brk_drv; brake_en_r |-> drive_en_r; endproperty
  property p_brk_lvl; brake_en_r |-> brake_level_r <= 11'h5dc; endproperty
  // Braking lasts at least one tick unless the run request drops in S_PRE, assuming the tick is eight cycles or more.
  property p_brk_len; $rose(brake_en_r) |-> brake_en_r [*8]; endproperty
  property p_learn_clr;
    learn_done && s_axi_awready |=> learn_sel_r == 2'd0;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  a_ar_block: assert property (p_ar_block) else $error("arready not low");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_wr_resp: assert property (p_wr_resp) else $error("no write answer");
  a_brk_drv: assert property (p_brk_drv) else $error("brake without drive");
  a_brk_lvl: assert property (p_brk_lvl) else $error("brake level high");
  a_brk_len: assert property (p_brk_len) else $error("brake too short");
  a_learn_clr: assert property (p_learn_clr) else $error("selector kept");
endmodule // dsb_seq_chk
bind dsb_sequencer dsb_seq_chk u_chk (.clk, .rst, .learn_done, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .drive_en_r, .brake_en_r, .brake_level_r, .learn_sel_r);

// file: tb/dsb_term_model.sv
`timescale 1ns/1ps
module dsb_term_model (
  input wire clk,
  input wire fwd_cmd,
  input wire rev_cmd,
  input wire learn_go,
  output reg run_fwd_pin,
  output reg run_rev_pin,
  output reg learn_done,
  output reg [79:0] learn_params
);
  initial begin
    run_fwd_pin = 1'b0;
    run_rev_pin = 1'b0;
    learn_done = 1'b0;
    learn_params = 80'h0;
  end
  // The terminals follow the commands one edge late, like contacts.
  always @(posedge clk) begin
    run_fwd_pin <= fwd_cmd;
    run_rev_pin <= rev_cmd;
  end
  // One done pulse with fresh values; otherwise values toggle so a late
  // capture is seen.
  always @(posedge clk) begin
    learn_done <= learn_go && !learn_done;
    learn_params <= learn_go ? 80'h0e05_0d04_0c03_0b02_0a01 : ~learn_params;
  end
endmodule // dsb_term_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "dsb_defines.vh"
module tb_top;
  reg clk, rst, ce, fwd, rv, lgo, awvalid, wvalid, bready, arvalid, rready;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, d;
  reg [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, rf, rr, ld, dir, den, ben;
  wire [1:0] bresp, rresp, lsel;
  wire [31:0] rdata;
  wire [79:0] lp;
  wire [15:0] freq;
  wire [10:0] blev;
  integer num_errors, checks_done, n;
  // Free running 100 ns clock.
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  dsb_term_model u_term (.clk(clk), .fwd_cmd(fwd), .rev_cmd(rv), .learn_go(lgo),
    .run_fwd_pin(rf), .run_rev_pin(rr), .learn_done(ld), .learn_params(lp));
  dsb_sequencer #(.TICK_CYCLES(24'd10)) DUT (.clk(clk), .rst(rst), .ce(ce),
    .run_fwd_pin(rf), .run_rev_pin(rr), .learn_done(ld), .learn_params(lp),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .out_freq_r(freq),
    .out_dir_r(dir), .drive_en_r(den), .brake_en_r(ben),
    .brake_level_r(blev), .learn_sel_r(lsel));
  task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (e !== g) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // Counts one more cycle of a wait and gives up past the limit.
  task tick(input integer lim);
    begin
      @(posedge clk);
      n = n + 1;
      if (n > lim) begin
        chk("wait", 0, 1);
        finish_test;
      end
    end
  endtask
  // Bus write; valids drop once taken, response held until bvalid.
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1; n = 0;
      do begin
        tick(60);
        if (awvalid && awready) awvalid <= 0;
        if (wvalid && wready) wvalid <= 0;
      end while (!bvalid);
      r = bresp;
      bready <= 0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      araddr <= a; arvalid <= 1; rready <= 1; n = 0;
      do begin
        tick(60);
        if (arvalid && arready) arvalid <= 0;
      end while (!rvalid);
      d = rdata; r = rresp;
      rready <= 0;
    end
  endtask
  task t_regs;
    begin
      rd(`DSB_A_CTRL); chk("ctrl", 32'h08, d);
      rd(`DSB_A_MAX_FREQ); chk("maxf", 32'h1388, d);
      rd(8'h38); chk("rresp", 2, r);
      wr(8'h02, 0); chk("bresp", 2, r);
      $display("regs done");
    end
  endtask
  task t_guard;
    begin
      repeat (60) @(posedge clk);
      chk("locked", 0, den);
      @(posedge clk); fwd <= 0;
      repeat (10) @(posedge clk); fwd <= 1; n = 0;
      while (!den) tick(20);
      chk("rearm", 1, den);
      wr(`DSB_A_TARGET, 50);
      @(posedge clk); ce <= 0;
      @(posedge clk); d = freq;
      repeat (25) @(posedge clk);
      chk("freeze", d, freq);
      ce <= 1; n = 0;
      while (freq !== 16'd50) tick(200);
      wr(`DSB_A_CTRL, 32'h0a);
      @(posedge clk); fwd <= 0; n = 0;
      while (den) tick(8);
      chk("coastf", 0, freq);
      $display("guard coast done");
    end
  endtask
  task t_pre;
    begin
      wr(`DSB_A_PRE_CUR, 100); wr(`DSB_A_PRE_DUR, 2);
      wr(`DSB_A_CTRL, 32'h0b);
      @(posedge clk); fwd <= 1; n = 0;
      while (!ben) tick(20);
      chk("prelev", 100, blev);
      n = 0;
      while (ben) tick(40);
      chk("predur", 1, n >= 18 && n <= 22);
      chk("accel", 1, den);
      @(posedge clk); fwd <= 0; n = 0;
      while (den) tick(8);
      wr(`DSB_A_PRE_DUR, 0);
      @(posedge clk); fwd <= 1; n = 0;
      while (!den) tick(20);
      chk("nobrake", 0, ben);
      $display("prestart done");
    end
  endtask
  task t_stop;
    begin
      wr(`DSB_A_CTRL, 32'h08); wr(`DSB_A_STOP_FREQ, 20);
      wr(`DSB_A_STOP_WAIT, 1); wr(`DSB_A_STOP_CUR, 32'h5dc);
      wr(`DSB_A_STOP_DUR, 2); wr(`DSB_A_DEAD, 2);
      @(posedge clk); fwd <= 0; rv <= 1; n = 0;
      while (freq !== 16'd0) tick(100);
      n = 0;
      while (!dir) tick(40);
      chk("dead", 1, n >= 18 && n <= 22);
      chk("revf", 0, freq);
      n = 0;
      while (freq !== 16'd50) tick(200);
      @(posedge clk); rv <= 0; n = 0;
      while (den) tick(200);
      chk("ramp", 1, n >= 33 && n <= 39);
      n = 0;
      while (!ben) tick(40);
      chk("wait", 1, n >= 8 && n <= 12);
      chk("stoplev", 32'h5dc, blev);
      n = 0;
      while (ben) tick(40);
      chk("stopdur", 1, n >= 18 && n <= 22);
      chk("idle", 0, den);
      $display("stop done");
    end
  endtask
  task t_param;
    begin
      wr(`DSB_A_RATED_PWR, 1);
      repeat (20) @(posedge clk);
      rd(`DSB_A_MP_BASE); chk("mp0", 32'h1388, d);
      rd(`DSB_A_MP_LAST); chk("mp8", 32'h1, d);
      wr(`DSB_A_LEARN_SEL, 1); chk("sel", 1, lsel);
      @(posedge clk); lgo <= 1;
      @(posedge clk); lgo <= 0;
      repeat (3) @(posedge clk);
      chk("selclr", 0, lsel);
      rd(8'h50); chk("stator", 32'h0a01, d);
      rd(`DSB_A_MP_LAST); chk("noload", 32'h0e05, d);
      $display("params done");
    end
  endtask
  // Second reset with the guard set just before power-on sampling.
  task t_auto;
    begin
      fwd <= 1; rst <= 1;
      repeat (3) @(posedge clk);
      rst <= 0;
      wr(`DSB_A_CTRL, 32'h0c); n = 0;
      while (!den) tick(20);
      chk("auto", 1, den);
      $display("auto start done");
    end
  endtask
  // Reset with the run terminal already active, then the scenarios.
  initial begin
    num_errors = 0; checks_done = 0; n = 0; rv = 0;
    rst = 1; ce = 1; fwd = 1; lgo = 0; awvalid = 0; wvalid = 0; bready = 0;
    arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
    repeat (3) @(posedge clk);
    rst <= 0;
    t_regs;
    t_guard;
    t_pre;
    t_stop;
    t_param;
    t_auto;
    finish_test;
  end
endmodule // tb_top
